// File: hw/i2c_slave_status_flags.sv
// Purpose: Slave-only two-wire link with status flags, APB registers, IRQ.
// Assumes: mclk 200 MHz, far more than the link bit rate; no clock stretching.
// Notes:   SDA is open drain: sdaOut is low, sdaOe pulls the line.
`timescale 1ns/1ps
module i2c_slave_status_flags (
	input  wire logic                                mclk,
	input  wire logic                                reset_n,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [i2c_flags_pkg::APB_AW-1:0]    paddr,
	input  wire logic [i2c_flags_pkg::APB_DW-1:0]    pwdata,
	output logic      [i2c_flags_pkg::APB_DW-1:0]    prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                sclIn,
	input  wire logic                                sdaIn,
	output logic                                     sdaOut,
	output logic                                     sdaOe,
	input  wire logic                                lowPower,
	output logic                                     wakeReq,
	output logic                                     irq
);
	import i2c_flags_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_SKIP
	} link_e;

	typedef struct packed {
		link_e             fsm;
		logic [3:0]        bitCnt;
		logic [7:0]        shift;
		logic [7:0]        txShift;
		logic [7:0]        txData;
		logic [7:0]        rxData;
		logic [6:0]        ownAddr;
		logic              done;
		logic              match;
		logic              busy;
		logic              dir;
		logic              ackCtl;
		logic              rw;
		logic              wakeEn;
		logic              ackRx;
		logic [IRQ_W-1:0]  irqSt;
		logic [IRQ_W-1:0]  irqMask;
		logic              irq;
		logic              wake;
		logic              sdaOe;
		logic              sdaOut;
		logic [APB_DW-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	logic sclS;
	logic sdaS;
	logic sclP;
	logic sdaP;

	line_sync u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.sclPin  (sclIn),
		.sdaPin  (sdaIn),
		.sclNow  (sclS),
		.sdaNow  (sdaS),
		.sclOld  (sclP),
		.sdaOld  (sdaP)
	);

	logic sclRise;
	logic sclFall;
	logic startDet;
	logic stopDet;
	logic addrHit;

	assign sclRise  = sclS && !sclP;
	assign sclFall  = !sclS && sclP;
	assign startDet = sclS && sclP && sdaP && !sdaS;
	assign stopDet  = sclS && sclP && !sdaP && sdaS;
	assign addrHit  = (s_r.shift[7:1] == s_r.ownAddr);

	function automatic logic [7:0] flagByte(input state_s st);
		logic [7:0] f;
		f              = 8'h00;
		f[BIT_DONE]    = st.done;
		f[BIT_MATCH]   = st.match;
		f[BIT_BUSY]    = st.busy;
		f[BIT_DIR]     = st.dir;
		f[BIT_ACKCTL]  = st.ackCtl;
		f[BIT_RW]      = st.rw;
		f[BIT_WAKEEN]  = st.wakeEn;
		f[BIT_ACKRX]   = st.ackRx;
		return f;
	endfunction : flagByte

	logic [IRQ_W-1:0] ev;
	logic             apbAccess;
	logic             apbCommit;
	logic [IRQ_W-1:0] w1c;

	always_comb begin
		s_nxt     = s_r;
		ev        = IRQ_NONE;
		w1c       = IRQ_NONE;
		apbAccess = psel && penable;
		apbCommit = apbAccess && s_r.pready;

		// Link side
		case (s_r.fsm)
			ST_IDLE: begin
			end
			ST_ADDR: begin
				if (sclRise) begin
					s_nxt.shift  = {s_r.shift[6:0], sdaS};
					s_nxt.bitCnt = s_r.bitCnt + 4'h1;
				end else if (sclFall && s_r.bitCnt == BITS_BYTE) begin
					if (addrHit) begin
						s_nxt.match = 1'b1;
						s_nxt.rw    = s_r.shift[0];
						s_nxt.sdaOe = 1'b1;
						s_nxt.fsm   = ST_ADDR_ACK;
						ev[IRQ_MATCH] = 1'b1;
						if (s_r.wakeEn && lowPower) begin
							s_nxt.wake = 1'b1;
						end
					end else begin
						s_nxt.match = 1'b0;
						s_nxt.fsm   = ST_SKIP;
					end
				end
			end
			ST_ADDR_ACK: begin
				if (sclFall) begin
					s_nxt.bitCnt = BITS_ZERO;
					s_nxt.done   = 1'b0;
					if (s_r.dir) begin
						s_nxt.txShift = s_r.txData;
						s_nxt.sdaOe   = !s_r.txData[7];
						s_nxt.fsm     = ST_TX;
					end else begin
						s_nxt.sdaOe = 1'b0;
						s_nxt.fsm   = ST_RX;
					end
				end
			end
			ST_RX: begin
				if (sclRise) begin
					s_nxt.shift  = {s_r.shift[6:0], sdaS};
					s_nxt.bitCnt = s_r.bitCnt + 4'h1;
				end else if (sclFall && s_r.bitCnt == BITS_BYTE) begin
					s_nxt.rxData = s_r.shift;
					s_nxt.done   = 1'b1;
					ev[IRQ_DONE] = 1'b1;
					// Ack level 0 pulls the line; 1 leaves it released
					s_nxt.sdaOe  = !s_r.ackCtl;
					s_nxt.fsm    = ST_RX_ACK;
				end
			end
			ST_RX_ACK: begin
				if (sclFall) begin
					s_nxt.sdaOe  = 1'b0;
					s_nxt.bitCnt = BITS_ZERO;
					s_nxt.done   = 1'b0;
					s_nxt.fsm    = ST_RX;
				end
			end
			ST_TX: begin
				if (sclRise) begin
					s_nxt.bitCnt = s_r.bitCnt + 4'h1;
				end else if (sclFall) begin
					if (s_r.bitCnt == BITS_BYTE) begin
						s_nxt.sdaOe = 1'b0;
						s_nxt.fsm   = ST_TX_ACK;
					end else begin
						s_nxt.txShift = {s_r.txShift[6:0], 1'b0};
						s_nxt.sdaOe   = !s_r.txShift[6];
					end
				end
			end
			ST_TX_ACK: begin
				if (sclRise) begin
					s_nxt.ackRx  = sdaS;
					s_nxt.done   = 1'b1;
					ev[IRQ_DONE] = 1'b1;
				end else if (sclFall) begin
					s_nxt.bitCnt = BITS_ZERO;
					if (!s_r.ackRx) begin
						s_nxt.txShift = s_r.txData;
						s_nxt.sdaOe   = !s_r.txData[7];
						s_nxt.done    = 1'b0;
						s_nxt.fsm     = ST_TX;
					end else begin
						// Release so the master can end with STOP
						s_nxt.sdaOe = 1'b0;
						s_nxt.fsm   = ST_SKIP;
					end
				end
			end
			ST_SKIP: begin
				s_nxt.sdaOe = 1'b0;
			end
			default: begin
				s_nxt.fsm = ST_IDLE;
			end
		endcase

		// START also covers repeated start mid-transfer
		if (startDet) begin
			s_nxt.busy   = 1'b1;
			s_nxt.fsm    = ST_ADDR;
			s_nxt.bitCnt = BITS_ZERO;
			s_nxt.shift  = 8'h00;
			s_nxt.match  = 1'b0;
			s_nxt.sdaOe  = 1'b0;
		end else if (stopDet) begin
			s_nxt.busy   = 1'b0;
			s_nxt.fsm    = ST_IDLE;
			s_nxt.sdaOe  = 1'b0;
			ev[IRQ_STOP] = 1'b1;
		end

		if (!lowPower) begin
			s_nxt.wake = 1'b0;
		end

		// APB: one wait cycle, write lands on the edge that samples pready
		s_nxt.pready  = apbAccess && !s_r.pready;
		s_nxt.pslverr = 1'b0;
		if (apbAccess && !s_r.pready) begin
			s_nxt.prdata = '0;
			case (paddr)
				OFS_FLAGS:    s_nxt.prdata[7:0] = flagByte(s_r);
				OFS_OWN_ADDR: s_nxt.prdata[7:0] = {s_r.ownAddr, 1'b0};
				OFS_DATA:     s_nxt.prdata[7:0] = s_r.rxData;
				OFS_IRQ_STAT: s_nxt.prdata[IRQ_W-1:0] = s_r.irqSt;
				OFS_IRQ_MASK: s_nxt.prdata[IRQ_W-1:0] = s_r.irqMask;
				default:      s_nxt.pslverr = 1'b1;
			endcase
		end
		if (apbCommit && pwrite) begin
			case (paddr)
				OFS_FLAGS: begin
					s_nxt.dir    = pwdata[BIT_DIR];
					s_nxt.ackCtl = pwdata[BIT_ACKCTL];
					s_nxt.wakeEn = pwdata[BIT_WAKEEN];
				end
				OFS_OWN_ADDR: s_nxt.ownAddr = pwdata[7:1];
				OFS_DATA:     s_nxt.txData  = pwdata[7:0];
				OFS_IRQ_STAT: w1c           = pwdata[IRQ_W-1:0];
				OFS_IRQ_MASK: s_nxt.irqMask = pwdata[IRQ_W-1:0];
				default: begin
				end
			endcase
		end

		// A new event wins over a clear in the same cycle
		s_nxt.irqSt = (s_r.irqSt & ~w1c) | ev;
		s_nxt.irq   = |(s_nxt.irqSt & s_nxt.irqMask);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_r         <= '0;
			s_r.fsm     <= ST_IDLE;
			s_r.done    <= FLAGS_RESET[BIT_DONE];
			s_r.ackRx   <= FLAGS_RESET[BIT_ACKRX];
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata  = s_r.prdata;
	assign pready  = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign sdaOut  = s_r.sdaOut;
	assign sdaOe   = s_r.sdaOe;
	assign wakeReq = s_r.wake;
	assign irq     = s_r.irq;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_busy_on_start: assert property (startDet |=> s_r.busy)
		else $error("busy flag not set after START");
	a_busy_on_stop: assert property (stopDet && !startDet |=> !s_r.busy)
		else $error("busy flag not cleared after STOP");
	a_match_ack: assert property (
		s_r.fsm == ST_ADDR && sclFall && s_r.bitCnt == BITS_BYTE && addrHit && !startDet
		|=> s_r.sdaOe && s_r.match && s_r.fsm == ST_ADDR_ACK)
		else $error("no ack driven after address match");
	a_no_match: assert property (
		s_r.fsm == ST_ADDR && sclFall && s_r.bitCnt == BITS_BYTE && !addrHit
		|=> !s_r.match && !s_r.sdaOe)
		else $error("match flag set on foreign address");
	a_rw_capture: assert property (
		s_r.fsm == ST_ADDR && sclFall && s_r.bitCnt == BITS_BYTE && addrHit
		|=> s_r.rw == $past(s_r.shift[0]))
		else $error("read/write flag not the eighth bit");
	a_rx_ack_drive: assert property (
		s_r.fsm == ST_RX && sclFall && s_r.bitCnt == BITS_BYTE && !startDet && !stopDet
		|=> s_r.sdaOe == !$past(s_r.ackCtl) && s_r.fsm == ST_RX_ACK)
		else $error("ack control bit not driven on ninth clock");
	a_ack_record: assert property (
		s_r.fsm == ST_TX_ACK && sclRise && !startDet && !stopDet
		|=> s_r.ackRx == $past(sdaS) && s_r.done)
		else $error("master ack not recorded");
	a_nack_release: assert property (
		s_r.fsm == ST_TX_ACK && sclFall && s_r.ackRx
		|=> !s_r.sdaOe ##1 (!s_r.sdaOe || startDet || $past(startDet)))
		else $error("SDA held after missing ack");
	a_dir_select: assert property (
		s_r.fsm == ST_ADDR_ACK && sclFall
		|=> (s_r.fsm == ST_TX) == $past(s_r.dir))
		else $error("direction bit not honoured");
	a_wake_match: assert property (
		s_r.fsm == ST_ADDR && sclFall && s_r.bitCnt == BITS_BYTE && addrHit
		&& s_r.wakeEn && lowPower && !startDet
		|=> s_r.wake)
		else $error("no wake on address match");
	a_done_irq: assert property (
		s_r.fsm == ST_RX && sclFall && s_r.bitCnt == BITS_BYTE && !startDet && !stopDet
		|=> s_r.done && s_r.irqSt[IRQ_DONE])
		else $error("byte done not flagged");
endmodule : i2c_slave_status_flags

// File: include/i2c_flags_pkg.sv
// Purpose: Shared constants for the slave status flag block.
// Assumes: APB byte addresses, one register per 32-bit word.
// Notes:   Flag layout matches the software view of slave_link_flags.
package i2c_flags_pkg;
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;

	// Register byte offsets
	localparam logic [APB_AW-1:0] OFS_FLAGS    = 8'h00;
	localparam logic [APB_AW-1:0] OFS_OWN_ADDR = 8'h04;
	localparam logic [APB_AW-1:0] OFS_DATA     = 8'h08;
	localparam logic [APB_AW-1:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h10;

	// slave_link_flags bit positions
	localparam int BIT_DONE   = 7;
	localparam int BIT_MATCH  = 6;
	localparam int BIT_BUSY   = 5;
	localparam int BIT_DIR    = 4;
	localparam int BIT_ACKCTL = 3;
	localparam int BIT_RW     = 2;
	localparam int BIT_WAKEEN = 1;
	localparam int BIT_ACKRX  = 0;

	// Interrupt event bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_MATCH   = 0;
	localparam int IRQ_DONE    = 1;
	localparam int IRQ_STOP    = 2;

	localparam logic [7:0]       FLAGS_RESET = 8'h81;
	localparam logic [3:0]       BITS_BYTE   = 4'h8;
	localparam logic [3:0]       BITS_ZERO   = 4'h0;
	localparam logic [IRQ_W-1:0] IRQ_NONE    = 3'h0;
endpackage : i2c_flags_pkg

// File: hw/line_sync.sv
// Purpose: Bring SCL and SDA into the mclk domain and keep one old sample.
// Assumes: Pins are asynchronous to mclk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module line_sync (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic sclPin,
	input  wire logic sdaPin,
	output logic      sclNow,
	output logic      sdaNow,
	output logic      sclOld,
	output logic      sdaOld
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] old;
	} sync_s;

	sync_s s_r;
	sync_s s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = {sclPin, sdaPin};
		s_nxt.sync = s_r.meta;
		s_nxt.old  = s_r.sync;
	end

	// Idle bus level is high, so reset to high avoids false edges
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sclNow = s_r.sync[1];
	assign sdaNow = s_r.sync[0];
	assign sclOld = s_r.old[1];
	assign sdaOld = s_r.old[0];
endmodule : line_sync

// File: verification/i2c_master_model.sv
// Purpose: Behavioural two-wire bus master driving SCL and pulling SDA.
// Assumes: SDA has a pull-up; sdaLine is the resolved wire level.
// Notes:   SCL period 125 ns; idle with SCL high between frames.
`timescale 1ns/1ps
module i2c_master_model (
	output logic      scl,
	output logic      sdaPull,
	input  wire logic sdaLine
);
	localparam realtime Q = 31.25;
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic bitx(input logic b, output logic r);
		sdaPull = ~b;
		#Q scl = 1'b1;
		#Q r = sdaLine;
		#Q scl = 1'b0;
		#Q;
	endtask : bitx
	task automatic start();
		sdaPull = 1'b0;
		#Q scl = 1'b1;
		#Q sdaPull = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask : start
	task automatic stop();
		sdaPull = 1'b1;
		#Q scl = 1'b1;
		#Q sdaPull = 1'b0;
		#(2 * Q);
	endtask : stop
	task automatic wrByte(input logic [7:0] v, output logic ack);
		logic d;
		for (int i = 7; i >= 0; i--) begin
			bitx(v[i], d);
		end
		bitx(1'b1, ack);
	endtask : wrByte
	// Master ack on the ninth clock; a nack asks the slave to let go
	task automatic rdByte(input logic nack, output logic [7:0] v);
		logic d;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, v[i]);
		end
		bitx(nack, d);
	endtask : rdByte
endmodule : i2c_master_model

// File: verification/tb_i2c_slave_status_flags.sv
// Purpose: Self-checking bench for the slave status flag block.
// Assumes: Own address 7'h52; irq mask all ones after the register rows.
// Notes:   Master model runs on its own timing, unrelated to mclk.
`timescale 1ns/1ps
module tb_i2c_slave_status_flags;
	import i2c_flags_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
	logic        mclk, reset_n, psel, penable, pwrite, lowPower;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        pready, pslverr, sdaOut, sdaOe, wakeReq, irq, scl, sdaPull, ack, err;
	logic [7:0]  bv;
	wire         sdaLine;
	int          n_mismatch, n_tests;
	row_s        rows [10];
	assign sdaLine = ~(sdaPull | sdaOe);
	i2c_slave_status_flags i2c_slave_status_flags_inst (.mclk(mclk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .lowPower(lowPower), .wakeReq(wakeReq), .irq(irq));
	i2c_master_model i2c_master_model_inst (.scl(scl), .sdaPull(sdaPull), .sdaLine(sdaLine));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	// Request held until pready seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// Taken at the edge that sees pready high, released on that same edge
		rv = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 50) check(32'h1, 32'h0);
	endtask : apb
	initial begin
		#100us;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, lowPower} = '0;
		rows = '{'{0, OFS_FLAGS, 0, 32'h81}, '{1, OFS_FLAGS, 32'hff, 0},
			'{0, OFS_FLAGS, 0, 32'h9b}, '{1, OFS_FLAGS, 0, 0}, '{0, OFS_FLAGS, 0, 32'h81},
			'{1, OFS_OWN_ADDR, 32'ha5, 0}, '{0, OFS_OWN_ADDR, 0, 32'ha4},
			'{0, 8'h14, 0, 0}, '{1, OFS_IRQ_MASK, 32'h7, 0}, '{0, OFS_IRQ_MASK, 0, 32'h7}};
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		check({sdaOe, wakeReq, irq}, 0);
		check(sdaOut, 0);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) check(rv, rows[i].e);
			check(err, rows[i].a == 8'h14);
		end
		$display("register test done");
		lowPower <= 1'b1;
		apb(1, OFS_FLAGS, 32'h02);
		i2c_master_model_inst.start();
		i2c_master_model_inst.wrByte(8'h22, ack);
		check(ack, 1);
		check(wakeReq, 0);
		apb(0, OFS_FLAGS, 0);
		check(rv[7:5], 3'b101);
		i2c_master_model_inst.stop();
		apb(0, OFS_FLAGS, 0);
		check(rv[BIT_BUSY], 0);
		apb(1, OFS_IRQ_STAT, 32'h7);
		$display("foreign address test done");
		i2c_master_model_inst.start();
		i2c_master_model_inst.wrByte({7'h52, 1'b0}, ack);
		check(ack, 0);
		check(wakeReq, 1);
		lowPower <= 1'b0;
		apb(1, OFS_FLAGS, 0);
		check(wakeReq, 0);
		apb(0, OFS_FLAGS, 0);
		check({rv[BIT_MATCH], rv[BIT_RW]}, 2'b10);
		check(irq, 1);
		apb(0, OFS_IRQ_STAT, 0);
		check(rv[IRQ_MATCH], 1);
		apb(1, OFS_IRQ_STAT, 32'h7);
		repeat (2) @(posedge mclk);
		check(irq, 0);
		i2c_master_model_inst.wrByte(8'h3c, ack);
		check(ack, 0);
		apb(0, OFS_DATA, 0);
		check(rv, 32'h3c);
		apb(0, OFS_IRQ_STAT, 0);
		check(rv[IRQ_DONE], 1);
		apb(1, OFS_FLAGS, 32'h08);
		i2c_master_model_inst.wrByte(8'hc3, ack);
		check(ack, 1);
		i2c_master_model_inst.stop();
		apb(0, OFS_IRQ_STAT, 0);
		check(rv[IRQ_STOP], 1);
		apb(1, OFS_FLAGS, 0);
		$display("receive test done");
		apb(1, OFS_DATA, 32'ha5);
		apb(1, OFS_FLAGS, 32'h10);
		i2c_master_model_inst.start();
		i2c_master_model_inst.wrByte({7'h52, 1'b1}, ack);
		check(ack, 0);
		apb(0, OFS_FLAGS, 0);
		check(rv[BIT_RW], 1);
		check(rv[BIT_DONE], 0);
		i2c_master_model_inst.rdByte(1'b0, bv);
		check(bv, 8'ha5);
		apb(0, OFS_FLAGS, 0);
		check(rv[BIT_ACKRX], 0);
		i2c_master_model_inst.rdByte(1'b1, bv);
		check(bv, 8'ha5);
		apb(0, OFS_FLAGS, 0);
		check(rv[BIT_ACKRX], 1);
		i2c_master_model_inst.rdByte(1'b1, bv);
		check(bv, 8'hff);
		i2c_master_model_inst.stop();
		$display("transmit test done");
		report_and_stop();
	end
endmodule : tb_i2c_slave_status_flags
